// File: bmd_pkg.sv
// Shared constants and types of the banked data memory decoder
package bmd_pkg;
  // Program side
  localparam int PC_W = 13;
  localparam int INSN_W = 14;
  // 13'h1fff for the 8K-word variant, 13'h0fff for the 4K-word variant
  localparam logic [12:0] PC_WRAP_MASK = 13'h1fff;
  localparam logic [12:0] RESET_VEC = 13'h0000;
  localparam logic [12:0] IRQ_VEC = 13'h0004;
  localparam int PC_LATCH_W = 5;
  // Register offsets inside a bank
  localparam logic [6:0] OFS_INDIRECT = 7'h00;
  localparam logic [6:0] OFS_PCL = 7'h02;
  localparam logic [6:0] OFS_STATUS = 7'h03;
  localparam logic [6:0] OFS_FSR = 7'h04;
  localparam logic [6:0] OFS_PORT_A_DATA = 7'h05;
  localparam logic [6:0] OFS_PC_HIGH_LATCH = 7'h0a;
  localparam logic [6:0] OFS_INTERRUPT_CONTROL_REG = 7'h0b;
  // Status fields
  localparam int ST_IRP = 7;
  localparam int ST_RP1 = 6;
  localparam int ST_RP0 = 5;
  localparam logic [7:0] STATUS_WMASK = 8'he7;
  // Reset values
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] FSR_RST = 8'h00;
  localparam logic [4:0] PC_HIGH_LATCH_RST = 5'h00;
  localparam logic [7:0] INTERRUPT_CONTROL_REG_RST = 8'h00;
  localparam logic [7:0] PORT_A_DATA_RST = 8'h00;
  // General purpose storage layout
  localparam int GPR_DEPTH = 368;
  localparam int GPR_IDX_W = 9;
  localparam logic [6:0] GPR_LO_B01 = 7'h20;
  localparam logic [6:0] GPR_LO_B23 = 7'h10;
  localparam logic [6:0] COMMON_LO = 7'h70;
  localparam logic [8:0] PH_B0 = 9'h000;
  localparam logic [8:0] PH_COMMON = 9'h050;
  localparam logic [8:0] PH_B1 = 9'h060;
  localparam logic [8:0] PH_B2 = 9'h0b0;
  localparam logic [8:0] PH_B3 = 9'h110;
  // Register bus
  localparam int WB_IDX_LSB = 2;

  typedef struct packed {
    logic hit;
    logic [8:0] idx;
  } bmd_gpr_hit_s;

  typedef enum logic [2:0] {
    BMD_T_NONE = 3'b000,
    BMD_T_PCL = 3'b001,
    BMD_T_STATUS = 3'b010,
    BMD_T_FSR = 3'b011,
    BMD_T_PC_HIGH_LATCH = 3'b100,
    BMD_T_INTERRUPT_CONTROL_REG = 3'b101,
    BMD_T_PORT_A_DATA = 3'b110,
    BMD_T_GPR = 3'b111
  } bmd_target_e;
endpackage : bmd_pkg

// File: bmd_core_if.sv
// Internal carrier between the decoder, the storage and the program counter
interface bmd_core_if;
  logic ram_we;
  logic [8:0] ram_idx;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  logic pcl_we;
  logic pc_high_latch_we;
  logic [7:0] pc_wdata;
  logic fetch_step;
  logic irq_take;
  logic [12:0] pc;
  logic [4:0] pc_latch;

  modport dec (
    output ram_we, ram_idx, ram_wdata, pcl_we, pc_high_latch_we, pc_wdata, fetch_step, irq_take,
    input ram_rdata, pc, pc_latch
  );
  modport ram (input ram_we, ram_idx, ram_wdata, output ram_rdata);
  modport pcu (input pcl_we, pc_high_latch_we, pc_wdata, fetch_step, irq_take, output pc, pc_latch);
endinterface : bmd_core_if

// File: bmd_gpr_ram.sv
// General purpose register storage in flip-flops
module bmd_gpr_ram (
  // Clock
  input wire logic clk_i,
  // Access from the decoder
  bmd_core_if.ram core
);
  logic [7:0] mem [bmd_pkg::GPR_DEPTH];
  logic [7:0] next_mem [bmd_pkg::GPR_DEPTH];

  // Contents are not reset: software must initialise what it reads
  for (genvar i = 0; i < bmd_pkg::GPR_DEPTH; i++) begin : g_word
    always_comb begin
      next_mem[i] = mem[i];
      if (core.ram_we && (core.ram_idx == 9'(i))) begin
        next_mem[i] = core.ram_wdata;
      end
    end
    always_ff @(posedge clk_i) begin
      mem[i] <= next_mem[i];
    end
  end

  assign core.ram_rdata = (core.ram_idx < 9'(bmd_pkg::GPR_DEPTH)) ? mem[core.ram_idx] : 8'h00;
endmodule : bmd_gpr_ram

// File: bmd_pc_unit.sv
// Program counter with high latch, vectors and wraparound
module bmd_pc_unit (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control from the decoder
  bmd_core_if.pcu core
);
  logic [12:0] pc;
  logic [12:0] next_pc;
  logic [4:0] latch;
  logic [4:0] next_latch;

  always_comb begin
    next_pc = pc;
    next_latch = latch;
    if (core.pc_high_latch_we) begin
      next_latch = core.pc_wdata[4:0];
    end
    // Interrupt wins over a bus write, which wins over a plain step
    if (core.irq_take) begin
      next_pc = bmd_pkg::IRQ_VEC;
    end else if (core.pcl_we) begin
      next_pc = {latch, core.pc_wdata} & bmd_pkg::PC_WRAP_MASK;
    end else if (core.fetch_step) begin
      next_pc = (pc + 13'h0001) & bmd_pkg::PC_WRAP_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc <= bmd_pkg::RESET_VEC;
      latch <= bmd_pkg::PC_HIGH_LATCH_RST;
    end else begin
      pc <= next_pc;
      latch <= next_latch;
    end
  end

  assign core.pc = pc;
  assign core.pc_latch = latch;

  reset_vector_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> (pc == 13'h0000)) else $error("pc not at reset vector");
  irq_vector_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      core.irq_take |=> (pc == 13'h0004)) else $error("pc not at interrupt vector");
  pc_wrap_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (core.fetch_step && !core.irq_take && !core.pcl_we && pc == bmd_pkg::PC_WRAP_MASK)
      |=> (pc == 13'h0000)) else $error("pc did not wrap");
  pcl_load_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (core.pcl_we && !core.irq_take) |=>
      (pc == ({$past(latch), $past(core.pc_wdata)} & bmd_pkg::PC_WRAP_MASK)))
      else $error("pc low byte write lost the latch");
endmodule : bmd_pc_unit

// File: bmd_decoder.sv
// Banked data memory decoder with program counter, behind a Wishbone slave
//
// Added by the designer: the Wishbone interface to the registers.
module bmd_decoder (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Instruction side
  input wire logic fetch_step_i,
  input wire logic irq_take_i,
  output logic [12:0] imem_addr_o,
  // Port A
  input wire logic [7:0] port_a_pins_i,
  output logic [7:0] port_a_latch_o,
  // Interrupt control value for the interrupt logic
  output logic [7:0] interrupt_control_o
);
  bmd_core_if core ();

  logic [7:0] core_status;
  logic [7:0] next_core_status;
  logic [7:0] file_pointer;
  logic [7:0] next_file_pointer;
  logic [7:0] interrupt_control_reg;
  logic [7:0] next_interrupt_control_reg;
  logic [7:0] port_a_data;
  logic [7:0] next_port_a_data;
  logic [31:0] rd_data;
  logic [31:0] next_rd_data;
  logic ack;
  logic next_ack;

  logic acc_new;
  logic adr_ok;
  logic indirect;
  logic wr;
  logic [6:0] reg_field;
  logic [8:0] eff_addr;
  logic [6:0] ofs;
  logic [1:0] bnk;
  bmd_pkg::bmd_gpr_hit_s gm;
  bmd_pkg::bmd_target_e target;
  logic [7:0] rd_byte;

  // Maps a 9-bit data address onto the physical general storage
  function automatic bmd_pkg::bmd_gpr_hit_s gpr_map(input logic [8:0] a);
    logic [6:0] o;
    logic [6:0] lo;
    logic [8:0] base;
    bmd_pkg::bmd_gpr_hit_s r;
    o = a[6:0];
    lo = a[8] ? bmd_pkg::GPR_LO_B23 : bmd_pkg::GPR_LO_B01;
    r.hit = 1'b0;
    r.idx = 9'h000;
    if (o >= bmd_pkg::COMMON_LO) begin
      r.hit = 1'b1;
      r.idx = bmd_pkg::PH_COMMON + {2'b00, o - bmd_pkg::COMMON_LO};
    end else if (o >= lo) begin
      if (a[8:7] == 2'b00) begin
        base = bmd_pkg::PH_B0;
      end else if (a[8:7] == 2'b01) begin
        base = bmd_pkg::PH_B1;
      end else if (a[8:7] == 2'b10) begin
        base = bmd_pkg::PH_B2;
      end else begin
        base = bmd_pkg::PH_B3;
      end
      r.hit = 1'b1;
      r.idx = base + {2'b00, o - lo};
    end
    return r;
  endfunction : gpr_map

  // Request and address formation
  assign acc_new = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign reg_field = wb_adr_i[8:2];
  assign adr_ok = (wb_adr_i[31:9] == 23'h000000) && (wb_adr_i[1:0] == 2'b00);
  assign indirect = (reg_field == bmd_pkg::OFS_INDIRECT);
  // Only the low byte lane carries data, so a write needs sel[0]
  assign wr = acc_new && wb_we_i && wb_sel_i[0];
  assign eff_addr = indirect ? {core_status[bmd_pkg::ST_IRP], file_pointer}
                             : {core_status[bmd_pkg::ST_RP1:bmd_pkg::ST_RP0], reg_field};
  assign ofs = eff_addr[6:0];
  assign bnk = eff_addr[8:7];
  assign gm = gpr_map(eff_addr);

  // Target decode
  always_comb begin
    target = bmd_pkg::BMD_T_NONE;
    if (!adr_ok) begin
      target = bmd_pkg::BMD_T_NONE;
    end else if (ofs == bmd_pkg::OFS_INDIRECT) begin
      // Pointer aimed at itself: nothing is stored there
      target = bmd_pkg::BMD_T_NONE;
    end else if (ofs == bmd_pkg::OFS_PCL) begin
      target = bmd_pkg::BMD_T_PCL;
    end else if (ofs == bmd_pkg::OFS_STATUS) begin
      target = bmd_pkg::BMD_T_STATUS;
    end else if (ofs == bmd_pkg::OFS_FSR) begin
      target = bmd_pkg::BMD_T_FSR;
    end else if (ofs == bmd_pkg::OFS_PC_HIGH_LATCH) begin
      target = bmd_pkg::BMD_T_PC_HIGH_LATCH;
    end else if (ofs == bmd_pkg::OFS_INTERRUPT_CONTROL_REG) begin
      target = bmd_pkg::BMD_T_INTERRUPT_CONTROL_REG;
    end else if ((ofs == bmd_pkg::OFS_PORT_A_DATA) && (bnk == 2'b00)) begin
      target = bmd_pkg::BMD_T_PORT_A_DATA;
    end else if (gm.hit) begin
      target = bmd_pkg::BMD_T_GPR;
    end
  end

  // Read multiplexer
  always_comb begin
    case (target)
      bmd_pkg::BMD_T_PCL: rd_byte = core.pc[7:0];
      bmd_pkg::BMD_T_STATUS: rd_byte = core_status;
      bmd_pkg::BMD_T_FSR: rd_byte = file_pointer;
      bmd_pkg::BMD_T_PC_HIGH_LATCH: rd_byte = {3'b000, core.pc_latch};
      bmd_pkg::BMD_T_INTERRUPT_CONTROL_REG: rd_byte = interrupt_control_reg;
      bmd_pkg::BMD_T_PORT_A_DATA: rd_byte = port_a_pins_i;
      bmd_pkg::BMD_T_GPR: rd_byte = core.ram_rdata;
      default: rd_byte = 8'h00;
    endcase
  end

  // Storage and program counter strobes
  assign core.ram_we = wr && (target == bmd_pkg::BMD_T_GPR);
  assign core.ram_idx = gm.idx;
  assign core.ram_wdata = wb_dat_i[7:0];
  // A bus write to the pc low byte redirects the next fetch
  assign core.pcl_we = wr && (target == bmd_pkg::BMD_T_PCL);
  assign core.pc_high_latch_we = wr && (target == bmd_pkg::BMD_T_PC_HIGH_LATCH);
  assign core.pc_wdata = wb_dat_i[7:0];
  // Fetch runs on its own port; an interrupt or a bus write to the pc low byte overrides its step
  assign core.fetch_step = fetch_step_i;
  assign core.irq_take = irq_take_i;

  // Core registers
  always_comb begin
    next_core_status = core_status;
    next_file_pointer = file_pointer;
    next_interrupt_control_reg = interrupt_control_reg;
    next_port_a_data = port_a_data;
    if (wr) begin
      case (target)
        bmd_pkg::BMD_T_STATUS: begin
          // Time-out and power-down flags stay read-only
          next_core_status = (core_status & ~bmd_pkg::STATUS_WMASK)
                             | (wb_dat_i[7:0] & bmd_pkg::STATUS_WMASK);
        end
        bmd_pkg::BMD_T_FSR: next_file_pointer = wb_dat_i[7:0];
        bmd_pkg::BMD_T_INTERRUPT_CONTROL_REG: next_interrupt_control_reg = wb_dat_i[7:0];
        bmd_pkg::BMD_T_PORT_A_DATA: next_port_a_data = wb_dat_i[7:0];
        default: next_core_status = core_status;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_status <= bmd_pkg::STATUS_RST;
      file_pointer <= bmd_pkg::FSR_RST;
      interrupt_control_reg <= bmd_pkg::INTERRUPT_CONTROL_REG_RST;
      port_a_data <= bmd_pkg::PORT_A_DATA_RST;
    end else begin
      core_status <= next_core_status;
      file_pointer <= next_file_pointer;
      interrupt_control_reg <= next_interrupt_control_reg;
      port_a_data <= next_port_a_data;
    end
  end

  // Bus answer: one cycle after the request, dropped the cycle after
  always_comb begin
    next_ack = acc_new;
    next_rd_data = 32'h00000000;
    if (acc_new && !wb_we_i) begin
      next_rd_data = {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rd_data <= 32'h00000000;
    end else begin
      ack <= next_ack;
      rd_data <= next_rd_data;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rd_data;
  assign imem_addr_o = core.pc;
  assign port_a_latch_o = port_a_data;
  assign interrupt_control_o = interrupt_control_reg;

  bmd_gpr_ram u_ram (
    .clk_i(clk_i),
    .core(core.ram)
  );

  bmd_pc_unit u_pc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .core(core.pcu)
  );

  ack_one_cycle_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      acc_new |=> wb_ack_o ##1 !wb_ack_o) else $error("bus answer not one cycle");
  fetch_parallel_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (acc_new && fetch_step_i && !irq_take_i && !core.pcl_we && core.pc != 13'h1fff)
      |=> wb_ack_o && (imem_addr_o == $past(core.pc) + 13'h0001))
      else $error("fetch stalled by data access");
  direct_bank_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (acc_new && !indirect) |-> (eff_addr[8:7] == core_status[6:5]) && (ofs == reg_field))
      else $error("direct bank wrong");
  indirect_addr_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (acc_new && indirect) |-> (eff_addr == {core_status[7], file_pointer}))
      else $error("indirect address wrong");
  common_area_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (acc_new && adr_ok && ofs[6:4] == 3'h7) |->
      (target == bmd_pkg::BMD_T_GPR) && (core.ram_idx == 9'h050 + {5'h00, ofs[3:0]}))
      else $error("common area not shared");
  no_store_self_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && ofs == 7'h00) |-> !core.ram_we && !core.pcl_we)
      else $error("write stored at pointer offset");
  unimpl_zero_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (acc_new && !wb_we_i && target == bmd_pkg::BMD_T_NONE) |=> (wb_dat_o == 32'h00000000))
      else $error("unimplemented read not zero");
  port_read_pins_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (acc_new && !wb_we_i && target == bmd_pkg::BMD_T_PORT_A_DATA) |=>
      (wb_dat_o[7:0] == $past(port_a_pins_i))) else $error("port read not from pins");
  port_write_latch_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && target == bmd_pkg::BMD_T_PORT_A_DATA) |=> (port_a_latch_o == $past(wb_dat_i[7:0])))
      else $error("port latch not written");
  interrupt_control_reg_mirror_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && adr_ok && ofs == 7'h0b) |=> (interrupt_control_o == $past(wb_dat_i[7:0])))
      else $error("mirrored control write lost");

  // Mirrored registers, port and storage limits, pc and status access, strobes refused outside the map, and the bus answer
  pc_high_latch_write_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && adr_ok && ofs == 7'h0a) |=> (core.pc_latch == $past(wb_dat_i[4:0])))
      else $error("high latch write lost");

  fsr_write_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && adr_ok && ofs == 7'h04) |=> (file_pointer == $past(wb_dat_i[7:0])))
      else $error("file pointer write lost");

  port_bank0_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (acc_new && adr_ok && ofs == 7'h05 && bnk != 2'b00) |-> (target == bmd_pkg::BMD_T_NONE))
      else $error("port reached outside bank 0");

  unmapped_write_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && !adr_ok) |-> !core.ram_we && !core.pcl_we && !core.pc_high_latch_we)
      else $error("unmapped write stored");

  gpr_range_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (acc_new && target == bmd_pkg::BMD_T_GPR) |-> (core.ram_idx < 9'h170))
      else $error("storage index out of range");

  pcl_read_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (acc_new && !wb_we_i && target == bmd_pkg::BMD_T_PCL) |=> (wb_dat_o[7:0] == $past(core.pc[7:0])))
      else $error("pc low byte read wrong");

  status_bank_write_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && target == bmd_pkg::BMD_T_STATUS) |=> (core_status[6:5] == $past(wb_dat_i[6:5])))
      else $error("bank bits not written");

  ack_after_request_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> $past(acc_new))
      else $error("answer without request");
endmodule : bmd_decoder

// File: bmd_core_model.sv
// Core model: register bus master, instruction-side controls and port pins
module bmd_core_model (
  // Clock
  input wire logic clk_i,
  // Wishbone master
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [31:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic wb_ack_i,
  // Instruction side
  output logic fetch_step_o,
  output logic irq_take_o,
  // Port pins
  output logic [7:0] port_a_pins_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 32'h00000000;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h00000000;
    fetch_step_o = 1'b0;
    irq_take_o = 1'b0;
    port_a_pins_o = 8'h00;
  end

  // One classic cycle, held until ack is sampled high or 16 edges have passed
  task automatic xfer(input logic we, input logic [6:0] ofs, input logic [1:0] lo,
                      input logic [3:0] sel, input logic [7:0] d, output bit ok);
    int n;
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= {23'h000000, ofs, lo};
    wb_sel_o <= sel;
    wb_dat_o <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_i !== 1'b1 && n < 16);
    ok = (wb_ack_i === 1'b1);
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
    // Released lines must not keep looking valid
    wb_adr_o <= ~wb_adr_o;
    wb_dat_o <= ~wb_dat_o;
  endtask : xfer

  // Fetch and interrupt levels held for a number of sampled edges
  task automatic run(input logic f, input logic i, input int cycles);
    @(posedge clk_i);
    fetch_step_o <= f;
    irq_take_o <= i;
    repeat (cycles) @(posedge clk_i);
    fetch_step_o <= 1'b0;
    irq_take_o <= 1'b0;
  endtask : run

  task automatic set_pins(input logic [7:0] v);
    @(posedge clk_i);
    port_a_pins_o <= v;
  endtask : set_pins
endmodule : bmd_core_model

// File: bmd_decoder_tb.sv
// Self-checking bench of the banked data memory decoder
module bmd_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_i;
  logic rst_i;
  logic wb_cyc, wb_stb, wb_we, wb_ack, fetch_step, irq_take;
  logic [31:0] wb_adr, wb_wdat, wb_rdat;
  logic [3:0] wb_sel;
  logic [12:0] imem_addr;
  logic [7:0] pins, latch, intctl, p;
  logic [7:0] v [4];
  logic [7:0] q [$];
  int n_fail = 0;
  int checks = 0;
  int seed = 2;

  bmd_decoder dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .fetch_step_i(fetch_step), .irq_take_i(irq_take),
    .imem_addr_o(imem_addr), .port_a_pins_i(pins), .port_a_latch_o(latch),
    .interrupt_control_o(intctl));

  bmd_core_model core (.clk_i(clk_i), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we),
    .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat), .wb_ack_i(wb_ack),
    .fetch_step_o(fetch_step), .irq_take_o(irq_take), .port_a_pins_o(pins));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic fail(input string m);
    $display("Error at %0t: %s", $time, m);
    n_fail++;
  endtask : fail

  task automatic finish_test();
    if (q.size() != 0) fail("answers missing");
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string m);
    checks++;
    if (got !== exp) fail(m);
  endtask : chk

  // Expected bus data is noted before the request goes out
  task automatic xfer(input logic we, input logic [6:0] ofs, input logic [1:0] lo,
                      input logic [3:0] sel, input logic [7:0] d, input logic [7:0] exp);
    bit ok;
    q.push_back(exp);
    core.xfer(we, ofs, lo, sel, d, ok);
    if (!ok) begin
      fail("no acknowledge");
      finish_test();
    end
  endtask : xfer

  task automatic wr(input logic [6:0] ofs, input logic [7:0] d);
    xfer(1'b1, ofs, 2'b00, 4'h1, d, 8'h00);
  endtask : wr

  task automatic rd(input logic [6:0] ofs, input logic [7:0] exp);
    xfer(1'b0, ofs, 2'b00, 4'h1, 8'h00, exp);
  endtask : rd

  always @(posedge clk_i) begin
    if (wb_ack === 1'b1) begin
      checks++;
      if (q.size() == 0) fail("unexpected acknowledge");
      else if (wb_rdat !== {24'h000000, q.pop_front()}) fail("bus data mismatch");
    end
  end

  initial begin
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk(imem_addr, bmd_pkg::RESET_VEC, "reset vector");
    chk({5'h00, intctl}, 13'h0000, "control reset");
    rd(bmd_pkg::OFS_STATUS, 8'h18);
    rd(bmd_pkg::OFS_FSR, 8'h00);
    rd(bmd_pkg::OFS_PC_HIGH_LATCH, 8'h00);
    rd(bmd_pkg::OFS_PCL, 8'h00);
    core.run(1'b1, 1'b0, 3);
    @(negedge clk_i);
    chk(imem_addr, 13'h0003, "fetch count");
    core.run(1'b0, 1'b1, 1);
    @(negedge clk_i);
    chk(imem_addr, bmd_pkg::IRQ_VEC, "interrupt vector");
    wr(bmd_pkg::OFS_PC_HIGH_LATCH, 8'hff);
    rd(bmd_pkg::OFS_PC_HIGH_LATCH, 8'h1f);
    chk(imem_addr, 13'h0004, "latch moved pc");
    wr(bmd_pkg::OFS_PCL, 8'hfe);
    @(negedge clk_i);
    chk(imem_addr, 13'h1ffe, "pc load");
    // Fetch and data read taken on the same edge
    fork
      rd(bmd_pkg::OFS_PCL, 8'hfe);
      core.run(1'b1, 1'b0, 1);
    join
    @(negedge clk_i);
    chk(imem_addr, 13'h1fff, "concurrent fetch");
    core.run(1'b1, 1'b0, 1);
    @(negedge clk_i);
    chk(imem_addr, 13'h0000, "wraparound");
    core.run(1'b1, 1'b1, 1);
    @(negedge clk_i);
    chk(imem_addr, 13'h0004, "interrupt priority");
    for (int b = 0; b < 4; b++) begin
      v[b] = 8'($random(seed));
      wr(bmd_pkg::OFS_STATUS, {1'b0, 2'(b), 5'h00});
      wr(7'h30, v[b]);
    end
    for (int b = 0; b < 4; b++) begin
      wr(bmd_pkg::OFS_STATUS, {1'b0, 2'(b), 5'h00});
      rd(bmd_pkg::OFS_STATUS, {1'b0, 2'(b), 5'h18});
      rd(7'h30, v[b]);
    end
    wr(7'h75, 8'h5a);
    wr(bmd_pkg::OFS_STATUS, 8'h00);
    rd(7'h75, 8'h5a);
    wr(bmd_pkg::OFS_STATUS, 8'h40);
    wr(bmd_pkg::OFS_INTERRUPT_CONTROL_REG, 8'hc3);
    chk({5'h00, intctl}, 13'h00c3, "control value");
    wr(bmd_pkg::OFS_STATUS, 8'h20);
    rd(bmd_pkg::OFS_INTERRUPT_CONTROL_REG, 8'hc3);
    wr(bmd_pkg::OFS_FSR, 8'h30);
    wr(bmd_pkg::OFS_STATUS, 8'h80);
    rd(bmd_pkg::OFS_INDIRECT, v[2]);
    wr(bmd_pkg::OFS_INDIRECT, 8'h77);
    wr(bmd_pkg::OFS_STATUS, 8'h40);
    rd(7'h30, 8'h77);
    wr(bmd_pkg::OFS_FSR, 8'h00);
    wr(bmd_pkg::OFS_INDIRECT, 8'h55);
    rd(bmd_pkg::OFS_INDIRECT, 8'h00);
    wr(bmd_pkg::OFS_STATUS, 8'h20);
    wr(bmd_pkg::OFS_PORT_A_DATA, 8'h11);
    rd(bmd_pkg::OFS_PORT_A_DATA, 8'h00);
    chk({5'h00, latch}, 13'h0000, "port latch outside bank 0");
    xfer(1'b0, 7'h30, 2'b01, 4'h1, 8'h00, 8'h00);
    xfer(1'b1, 7'h30, 2'b00, 4'he, 8'h99, 8'h00);
    xfer(1'b1, 7'h30, 2'b01, 4'h1, 8'h99, 8'h00);
    rd(7'h30, v[1]);
    wr(bmd_pkg::OFS_STATUS, 8'h00);
    p = 8'($random(seed));
    if (p == 8'h3c) p = 8'hc3;
    core.set_pins(p);
    wr(bmd_pkg::OFS_PORT_A_DATA, 8'h3c);
    chk({5'h00, latch}, 13'h003c, "port latch");
    rd(bmd_pkg::OFS_PORT_A_DATA, p);
    repeat (2) @(posedge clk_i);
    finish_test();
  end
endmodule : bmd_decoder_tb
